/* File: verilog/axcl_regs.svh */
// Codes, status positions, reset values and timing counts of the compare unit
//
// Contract
// - Latch edge rising at 0, falling at 1; axes 0 and 1 always latch on the rising edge
// - Capture the selected counter on a latch
// - Latch source: pin, comparator 4, 5, home
// - Separate positive and negative soft bounds
// - Soft bound reaction: event, stop, ramp stop
// - Out-of-step check with tolerance and enable
// - General comparator source selected by code
// - Equality methods with direction qualifiers
// - Methods 4 and 5 compare greater, less
// - General match reaction: event, stop, ramp, speed
// - Trigger polarity idles high at 0, low at 1
// - Read back compare values by selector
// - Status bits high while comparator satisfied; trigger bit held low in TRG_IDLE and TRG_WAIT
// - Trigger comparator only on axes 0 and 1
// - Auto continuous trigger compare from FIFO
// - Reload from RAM service or FIFO
// - Speed change uses programmed profile values
// - Event bit 10 on error over tolerance
// - Event bit 11 on general comparator reach
// - Trigger match pulses output, event bit 12
`ifndef AXCL_REGS_SVH
`define AXCL_REGS_SVH
// ==========================================================
// Compare methods and reactions
`define AXCL_METH_OFF 3'h0
`define AXCL_METH_EQ 3'h1
`define AXCL_METH_EQ_POS 3'h2
`define AXCL_METH_EQ_NEG 3'h3
`define AXCL_METH_GT 3'h4
`define AXCL_METH_LT 3'h5
`define AXCL_ACT_EVENT 2'h0
`define AXCL_ACT_STOP 2'h1
`define AXCL_ACT_RAMP 2'h2
`define AXCL_ACT_SPEED 2'h3
// ==========================================================
// Source, latch and readback codes
`define AXCL_SRC_CMD 2'h0
`define AXCL_SRC_FB 2'h1
`define AXCL_SRC_ERR 2'h2
`define AXCL_SRC_GP 2'h3
`define AXCL_LCNT_CMD 3'h1
`define AXCL_LCNT_FB 3'h2
`define AXCL_LCNT_ERR 3'h3
`define AXCL_LCNT_GP 3'h4
`define AXCL_LSRC_PIN 2'h0
`define AXCL_LSRC_CMP4 2'h1
`define AXCL_LSRC_CMP5 2'h2
`define AXCL_LSRC_HOME 2'h3
`define AXCL_RB_POS 3'h1
`define AXCL_RB_NEG 3'h2
`define AXCL_RB_ERR 3'h3
`define AXCL_RB_GP 3'h4
`define AXCL_RB_TRG 3'h5
// ==========================================================
// Status and event positions
`define AXCL_STS_POS 0
`define AXCL_STS_NEG 1
`define AXCL_STS_ERR 2
`define AXCL_STS_GP 3
`define AXCL_STS_TRG 4
`define AXCL_EVT_ERR_BIT 10
`define AXCL_EVT_GP_BIT 11
`define AXCL_EVT_TRG_BIT 12
// ==========================================================
// Reset values and timing
`define AXCL_TRIG_OUT_RST 1'b1
`define AXCL_CNT_RST 32'h0000_0000
`define AXCL_CLK_NS 10
`define AXCL_TRIG_PULSE_NS 1000
`define AXCL_TRIG_PULSE_CYC \
    ((`AXCL_TRIG_PULSE_NS + `AXCL_CLK_NS - 1) / `AXCL_CLK_NS)
`endif

/* File: verilog/axcl_pkg.sv */
// Types shared by the compare and latch unit
package axcl_pkg;
    typedef enum logic [4:0] {
        TRG_IDLE = 5'b00001,
        TRG_ARMED = 5'b00010,
        TRG_PULSE = 5'b00100,
        TRG_HOLD = 5'b01000,
        TRG_WAIT = 5'b10000
    } axcl_trg_type;
    typedef struct packed {
        logic signed [31:0] cmd;
        logic signed [31:0] fb;
        logic signed [31:0] err;
        logic signed [31:0] gp;
    } axcl_cnt_type;
    typedef struct packed {
        logic signed [31:0] res_dist;
        logic [31:0] cmp_vel;
        logic [31:0] new_vel;
        logic [31:0] ramp_time;
    } axcl_prof_type;
    typedef struct packed {
        logic signed [31:0] positive_soft_bound;
        logic signed [31:0] negative_soft_bound;
        logic soft_en;
        logic [1:0] soft_act;
        logic [15:0] tol;
        logic oos_en;
        logic [1:0] compare_source_select;
        logic [2:0] compare_method_select;
        logic [1:0] compare_reaction_select;
        logic signed [31:0] gp_val;
        logic [2:0] trg_method;
        logic signed [31:0] trg_val;
        logic trigger_polarity_select;
        logic auto_reload_select;
        logic reload_dev;
        logic latch_edge;
        logic [1:0] latch_src;
        logic [2:0] latch_cnt;
        logic [2:0] comparator_readback_select;
    } axcl_cfg_type;
    typedef struct packed {
        logic err;
        logic gp;
        logic trg;
        logic pos_bound;
        logic neg_bound;
    } axcl_evt_type;
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic signed [31:0] gp_prev;
        logic gp_up;
        logic signed [31:0] fb_prev;
        logic fb_up;
        logic [4:0] sts;
        axcl_trg_type st;
        logic [7:0] pcnt;
        logic signed [31:0] trg_act;
        logic have_next;
        logic trg_out;
        logic signed [31:0] latch_val;
        logic latch_valid;
        logic stop_now;
        logic ramp_stop;
        logic speed_change;
        axcl_prof_type prof;
        axcl_evt_type ev;
        logic ram_req;
        logic signed [31:0] rb;
    } axcl_state_type;
endpackage : axcl_pkg

/* File: verilog/axcl_unit.sv */
// Per-axis compare, trigger and latch logic
`timescale 1ns/1ps
`include "axcl_regs.svh"
module axcl_unit import axcl_pkg::*; #(
    parameter int AXIS_INDEX = 0,
    parameter logic [7:0] PULSE_CYC = 8'(`AXCL_TRIG_PULSE_CYC)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host set-up
    input wire axcl_cfg_type cfg,
    input wire axcl_prof_type prof_in,
    // Axis counters
    input wire axcl_cnt_type cnt,
    // Drive side pins
    input wire logic latch_pin,
    input wire logic home_sensor_input,
    output logic trig_out,
    // Compare value FIFO
    input wire logic fifo_valid,
    input wire logic signed [31:0] fifo_data,
    output logic fifo_ready,
    // RAM reload service
    output logic ram_reload_req,
    input wire logic ram_load,
    input wire logic signed [31:0] ram_data,
    // Reactions and events
    output logic stop_now,
    output logic ramp_stop,
    output logic speed_change,
    output axcl_prof_type prof_out,
    output axcl_evt_type events,
    // Status and readback
    output logic [4:0] cmp_status,
    output logic signed [31:0] readback,
    output logic signed [31:0] latch_val,
    output logic latch_valid
);
    localparam bit TRG_ON = (AXIS_INDEX < 2);
    localparam bit EDGE_SEL = (AXIS_INDEX >= 2);

    axcl_state_type q, d;
    logic [4:0] hit;
    logic signed [31:0] gp_cnt, trg_cmp, err_abs, lcnt;
    logic gp_step_up, fb_step_up, fire, lpin_evt, home_evt, latch_evt;
    logic auto_fifo, auto_ram, gp_rise;

    // ==========================================================
    // Decoders
    function automatic logic signed [31:0] pick_src(
        input axcl_cnt_type c, input logic [1:0] s);
        case (s)
            `AXCL_SRC_CMD: pick_src = c.cmd;
            `AXCL_SRC_FB: pick_src = c.fb;
            `AXCL_SRC_ERR: pick_src = c.err;
            default: pick_src = c.gp;
        endcase
    endfunction : pick_src

    function automatic logic cmp_hit(input logic [2:0] m,
        input logic signed [31:0] v, input logic signed [31:0] c,
        input logic up);
        case (m)
            `AXCL_METH_EQ: cmp_hit = (v == c);
            `AXCL_METH_EQ_POS: cmp_hit = (v == c) && up;
            `AXCL_METH_EQ_NEG: cmp_hit = (v == c) && !up;
            `AXCL_METH_GT: cmp_hit = (v > c);
            `AXCL_METH_LT: cmp_hit = (v < c);
            default: cmp_hit = 1'b0;
        endcase
    endfunction : cmp_hit

    // ==========================================================
    // Comparators
    // General source select
    assign gp_cnt = pick_src(cnt, cfg.compare_source_select);
    // Direction holds while the counter rests
    assign gp_step_up = (gp_cnt != q.gp_prev) ? (gp_cnt > q.gp_prev)
                                              : q.gp_up;
    assign fb_step_up = (cnt.fb != q.fb_prev) ? (cnt.fb > q.fb_prev)
                                              : q.fb_up;
    assign err_abs = cnt.err[31] ? -cnt.err : cnt.err;
    assign auto_fifo = cfg.auto_reload_select && cfg.reload_dev;
    assign auto_ram = cfg.auto_reload_select && !cfg.reload_dev;
    assign trg_cmp = cfg.auto_reload_select ? q.trg_act : cfg.trg_val;

    always_comb begin
        hit[`AXCL_STS_POS] = cfg.soft_en &&
            (cnt.cmd >= cfg.positive_soft_bound);
        hit[`AXCL_STS_NEG] = cfg.soft_en &&
            (cnt.cmd <= cfg.negative_soft_bound);
        hit[`AXCL_STS_ERR] = cfg.oos_en &&
            (err_abs > $signed({16'h0000, cfg.tol}));
        hit[`AXCL_STS_GP] = cmp_hit(cfg.compare_method_select,
            cfg.gp_val, gp_cnt, gp_step_up);
        // Trigger only on first two axes
        hit[`AXCL_STS_TRG] = TRG_ON && !q.st[0] && !q.st[4] &&
            cmp_hit(cfg.trg_method, trg_cmp, cnt.fb, fb_step_up);
    end

    assign gp_rise = hit[`AXCL_STS_GP] && !q.sts[`AXCL_STS_GP];
    assign fire = (q.st == TRG_ARMED) && hit[`AXCL_STS_TRG];

    // ==========================================================
    // Latch event decode
    // Edge select on axes 2 and above
    assign lpin_evt = (EDGE_SEL && cfg.latch_edge) ?
        (!q.s2[0] && q.s3[0]) : (q.s2[0] && !q.s3[0]);
    assign home_evt = q.s2[1] && !q.s3[1];

    always_comb begin
        case (cfg.latch_src)
            `AXCL_LSRC_PIN: latch_evt = lpin_evt;
            `AXCL_LSRC_CMP4: latch_evt = gp_rise;
            `AXCL_LSRC_CMP5: latch_evt = fire;
            default: latch_evt = home_evt;
        endcase
        case (cfg.latch_cnt)
            `AXCL_LCNT_FB: lcnt = cnt.fb;
            `AXCL_LCNT_ERR: lcnt = cnt.err;
            `AXCL_LCNT_GP: lcnt = cnt.gp;
            default: lcnt = cnt.cmd;
        endcase
    end

    // Pop on match, when starting, in TRG_PULSE until a word is held, and in TRG_WAIT
    // Idle pops only once a method is set, else the word is lost
    assign fifo_ready = TRG_ON && auto_fifo &&
        (fire || (q.st == TRG_IDLE && cfg.trg_method != `AXCL_METH_OFF)
         || (q.st == TRG_PULSE && !q.have_next) || q.st == TRG_WAIT);

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.s1 = {home_sensor_input, latch_pin};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.gp_prev = gp_cnt;
        d.gp_up = gp_step_up;
        d.fb_prev = cnt.fb;
        d.fb_up = fb_step_up;
        d.sts = hit;
        d.stop_now = 1'b0;
        d.ramp_stop = 1'b0;
        d.speed_change = 1'b0;
        d.ev = '0;
        d.ev.err = hit[`AXCL_STS_ERR] && !q.sts[`AXCL_STS_ERR];
        d.ev.gp = gp_rise;
        for (int i = 0; i < 2; i++) begin
            if (hit[i] && !q.sts[i]) begin
                case (cfg.soft_act)
                    `AXCL_ACT_STOP: d.stop_now = 1'b1;
                    `AXCL_ACT_RAMP: d.ramp_stop = 1'b1;
                    default: ;
                endcase
            end
        end
        d.ev.pos_bound = hit[`AXCL_STS_POS] && !q.sts[`AXCL_STS_POS];
        d.ev.neg_bound = hit[`AXCL_STS_NEG] && !q.sts[`AXCL_STS_NEG];
        if (gp_rise) begin
            case (cfg.compare_reaction_select)
                `AXCL_ACT_STOP: d.stop_now = 1'b1;
                `AXCL_ACT_RAMP: d.ramp_stop = 1'b1;
                `AXCL_ACT_SPEED: begin
                    d.speed_change = 1'b1;
                    d.prof = prof_in;
                end
                default: ;
            endcase
        end
        if (latch_evt) begin
            d.latch_val = lcnt;
            d.latch_valid = 1'b1;
        end
        case (cfg.comparator_readback_select)
            `AXCL_RB_POS: d.rb = cfg.positive_soft_bound;
            `AXCL_RB_NEG: d.rb = cfg.negative_soft_bound;
            `AXCL_RB_ERR: d.rb = $signed({16'h0000, cfg.tol});
            `AXCL_RB_GP: d.rb = cfg.gp_val;
            `AXCL_RB_TRG: d.rb = TRG_ON ? trg_cmp : `AXCL_CNT_RST;
            default: d.rb = `AXCL_CNT_RST;
        endcase
        // Trigger sequencer
        case (q.st)
            TRG_IDLE: begin
                if (TRG_ON && cfg.trg_method != `AXCL_METH_OFF) begin
                    if (auto_fifo) begin
                        if (fifo_valid) begin
                            d.trg_act = fifo_data;
                            d.st = TRG_ARMED;
                        end
                    end else if (auto_ram) begin
                        d.ram_req = 1'b1;
                        d.st = TRG_WAIT;
                    end else begin
                        d.st = TRG_ARMED;
                    end
                end
            end
            TRG_ARMED: begin
                if (fire) begin
                    d.ev.trg = 1'b1;
                    d.pcnt = PULSE_CYC;
                    d.st = TRG_PULSE;
                    d.have_next = auto_fifo && fifo_valid;
                    if (auto_fifo && fifo_valid) begin
                        d.trg_act = fifo_data;
                    end
                end else if (cfg.trg_method == `AXCL_METH_OFF) begin
                    d.st = TRG_IDLE;
                end
            end
            TRG_PULSE: begin
                if (auto_fifo && !q.have_next && fifo_valid) begin
                    d.trg_act = fifo_data;
                    d.have_next = 1'b1;
                end
                if (q.pcnt > 8'h01) begin
                    d.pcnt = q.pcnt - 8'h01;
                end else if (auto_fifo) begin
                    // Empty FIFO leaves the comparator in TRG_WAIT for the next word
                    d.st = d.have_next ? TRG_ARMED : TRG_WAIT;
                end else if (auto_ram) begin
                    d.ram_req = 1'b1;
                    d.st = TRG_WAIT;
                end else begin
                    d.st = TRG_HOLD;
                end
            end
            TRG_HOLD: begin
                // Re-arm once the match clears or auto reload is selected, else it retriggers
                if (!cmp_hit(cfg.trg_method, trg_cmp, cnt.fb, fb_step_up)
                    || cfg.auto_reload_select) begin
                    d.st = TRG_ARMED;
                end
            end
            TRG_WAIT: begin
                if (!cfg.auto_reload_select) begin
                    d.ram_req = 1'b0;
                    d.st = TRG_IDLE;
                end else if (auto_fifo && fifo_valid) begin
                    d.trg_act = fifo_data;
                    d.ram_req = 1'b0;
                    d.st = TRG_ARMED;
                end else if (auto_ram && ram_load) begin
                    d.trg_act = ram_data;
                    d.ram_req = 1'b0;
                    d.st = TRG_ARMED;
                end
            end
            default: d.st = TRG_IDLE;
        endcase
        d.trg_out = (d.st == TRG_PULSE) ? cfg.trigger_polarity_select
                                        : !cfg.trigger_polarity_select;
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= TRG_IDLE;
            q.trg_out <= `AXCL_TRIG_OUT_RST;
        end else begin
            q <= d;
        end
    end

    assign trig_out = q.trg_out;
    assign cmp_status = q.sts;
    assign events = q.ev;
    assign stop_now = q.stop_now;
    assign ramp_stop = q.ramp_stop;
    assign speed_change = q.speed_change;
    assign prof_out = q.prof;
    assign ram_reload_req = q.ram_req;
    assign readback = q.rb;
    assign latch_val = q.latch_val;
    assign latch_valid = q.latch_valid;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_ERR_EVENT: assert property (
        hit[`AXCL_STS_ERR] && !q.sts[`AXCL_STS_ERR] |=> events.err)
        else $error("error event missing");
    AST_GP_EVENT: assert property (
        gp_rise |=> events.gp && cmp_status[`AXCL_STS_GP])
        else $error("general event missing");
    AST_STATUS_LAG: assert property (
        ##1 cmp_status == $past(hit))
        else $error("status late");
    AST_GP_STOP: assert property (
        gp_rise && cfg.compare_reaction_select == `AXCL_ACT_STOP
        |=> stop_now)
        else $error("general stop missing");
    AST_OOS_OFF: assert property (
        !cfg.oos_en |=> !cmp_status[`AXCL_STS_ERR])
        else $error("disabled check reported");
    AST_TRG_FIRE: assert property (
        fire |=> events.trg && trig_out == $past(cfg.trigger_polarity_select))
        else $error("trigger pulse missing");
    AST_TRG_IDLE: assert property (
        q.st != TRG_PULSE && $past(q.st) != TRG_PULSE && $stable(
        cfg.trigger_polarity_select) |-> trig_out ==
        !cfg.trigger_polarity_select)
        else $error("trigger idle level wrong");
    AST_NO_TRG: assert property (
        !TRG_ON |-> !cmp_status[`AXCL_STS_TRG] && !fifo_ready)
        else $error("trigger on wrong axis");
    AST_LATCH: assert property (
        latch_evt |=> latch_valid && latch_val == $past(lcnt))
        else $error("latch value wrong");
    AST_FIFO_POP: assert property (
        fire && auto_fifo && fifo_valid |-> fifo_ready ##1
        q.trg_act == $past(fifo_data))
        else $error("fifo reload missing");
    COV_TRG: cover property (fire ##1 q.st == TRG_PULSE);
    COV_SPEED: cover property (speed_change);
    COV_LATCH: cover property (latch_evt && cfg.latch_src ==
        `AXCL_LSRC_PIN);
    COV_EMPTY: cover property (q.st == TRG_PULSE ##1 q.st == TRG_WAIT);
endmodule : axcl_unit

/* File: tb/axcl_drive_model.sv */
// Drive-side model: axis counters and sensor pins of one axis
`timescale 1ns/1ps
module axcl_drive_model import axcl_pkg::*; (
    // Motion set-points from the bench
    input wire logic signed [31:0] cmd_pos,
    input wire logic signed [31:0] lag,
    input wire logic signed [31:0] gp_pos,
    input wire logic ltc_lvl,
    input wire logic home_lvl,
    // Encoder and sensor side
    output axcl_cnt_type cnt,
    output logic latch_pin,
    output logic home_sensor_input
);
    // ====================================
    // Counters
    // Feedback trails the command by the lag, so a comparator that
    // picks the wrong counter sees a different value
    assign cnt.cmd = cmd_pos;
    assign cnt.fb = cmd_pos - lag;
    assign cnt.err = lag;
    assign cnt.gp = gp_pos;
    // ====================================
    // Sensor pins
    assign latch_pin = ltc_lvl;
    assign home_sensor_input = home_lvl;
endmodule : axcl_drive_model

/* File: tb/testbench.sv */
// Self-checking bench for the per-axis compare and latch unit
`timescale 1ns/1ps
`include "axcl_regs.svh"
module testbench import axcl_pkg::*; ();
    // ====================================
    // Signals
    typedef struct packed {
        int due;
        logic [127:0] val;
        logic [3:0] kind;
    } axcl_note_type;
    localparam int PCYC = 3;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    axcl_cfg_type cfg = '0;
    axcl_prof_type prof_in = '0;
    axcl_prof_type prof_out;
    axcl_cnt_type cnt;
    axcl_evt_type events;
    logic signed [31:0] cmd_pos = '0, lag = '0, gp_pos = '0;
    logic signed [31:0] fifo_data = '0, ram_data = '0;
    logic signed [31:0] readback, latch_val;
    logic ltc_lvl = 1'b0, home_lvl = 1'b0, latch_pin, home_sensor_input;
    logic fifo_valid = 1'b0, ram_load = 1'b0, fifo_ready, ram_req;
    logic trig_out, stop_now, ramp_stop, speed_change, latch_valid;
    logic [4:0] cmp_status;
    logic [2:0] tbl [6] = '{3'h0, 3'h2, 3'h2, 3'h0, 3'h4, 3'h1};
    logic [31:0] v, old;
    logic prev, hit;
    axcl_note_type q[$];
    int cyc = 0, error_cnt = 0, comparisons = 0, seed = 66479;
    int i, m, a;
    // ====================================
    // Instances
    axcl_unit #(.AXIS_INDEX(0), .PULSE_CYC(8'(PCYC))) axcl_unit_i (
        .ref_clk, .rst, .cfg, .prof_in, .cnt, .latch_pin,
        .home_sensor_input, .trig_out, .fifo_valid, .fifo_data,
        .fifo_ready, .ram_reload_req(ram_req), .ram_load, .ram_data,
        .stop_now, .ramp_stop, .speed_change, .prof_out, .events,
        .cmp_status, .readback, .latch_val, .latch_valid
    );
    axcl_drive_model axcl_drive_model_i (
        .cmd_pos, .lag, .gp_pos, .ltc_lvl, .home_lvl, .cnt,
        .latch_pin, .home_sensor_input
    );
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // ====================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // Notes must be pushed in order of due cycle
    task automatic note(input int d, input int k, input logic [127:0] x);
        q.push_back('{due: cyc + d, val: x, kind: k[3:0]});
    endtask : note
    task automatic compare(input logic [127:0] got, input logic [127:0] x);
        comparisons++;
        if (got !== x) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, x);
        end
    endtask : compare
    function automatic logic [127:0] pick(input logic [3:0] k);
        case (k)
            4'h0: return 128'(cmp_status);
            4'h1: return 128'(events);
            4'h2: return 128'(trig_out);
            4'h3: return {96'h0, readback};
            4'h4: return 128'({stop_now, ramp_stop, speed_change});
            4'h5: return prof_out;
            4'h7: return 128'({fifo_ready, ram_req});
            default: return {95'h0, latch_valid, latch_val};
        endcase
    endfunction : pick
    task automatic end_sim();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    // ====================================
    // Monitor: outputs are registered, so look 2 ns after the edge
    initial begin
        forever begin
            @(posedge ref_clk);
            cyc++;
            #2;
            while (q.size() > 0 && q[0].due <= cyc) begin
                compare(pick(q[0].kind), q[0].val);
                void'(q.pop_front());
            end
        end
    end
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
    // ====================================
    // Stimulus
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        note(1, 0, '0);
        note(1, 2, 128'h1);
        v = ($random(seed) & 32'h0000_FFFF) + 32'h0000_0010;
        prof_in = {$random(seed), $random(seed), $random(seed), $random(seed)};
        tick(4);
        cmd_pos = 32'h0000_0100;
        lag = 32'h0000_0010;
        gp_pos = 32'h0000_0300;
        cfg.compare_method_select = `AXCL_METH_EQ;
        for (i = 0; i < 4; i++) begin
            cfg.compare_source_select = i[1:0];
            cfg.gp_val = (i == 0) ? 32'h0000_0100 : (i == 1) ? 32'h0000_00F0
                : (i == 2) ? 32'h0000_0010 : 32'h0000_0300;
            note(1, 0, 128'h8);
            tick(1);
        end
        lag = '0;
        cfg.compare_source_select = `AXCL_SRC_FB;
        cfg.gp_val = v;
        // Methods 0 to 5 get reactions 0, 3, 2, 2, 1, 0 so all four are seen
        for (m = 0; m < 6; m++) begin
            a = (m < 3) ? 4 - m : 5 - m;
            cfg.compare_method_select = m[2:0];
            cfg.compare_reaction_select = a[1:0];
            cmd_pos = v + 5;
            tick(3);
            prev = (m == 5);
            for (i = 2; i >= 0; i--) begin
                cmd_pos = v + 1 - i;
                hit = tbl[m][i];
                note(1, 0, 128'(hit) << 3);
                note(1, 1, 128'(hit && !prev) << 3);
                note(1, 4, (hit && !prev && a > 0)
                    ? 128'(3'h4 >> (a - 1)) : '0);
                if (m == 1 && i == 1) note(2, 5, prof_in);
                prev = hit;
                tick(1);
            end
        end
        cfg.compare_method_select = `AXCL_METH_OFF;
        cfg.positive_soft_bound = 32'h0000_1000;
        cfg.negative_soft_bound = 32'hFFFF_F000;
        cfg.soft_en = 1'b1;
        for (a = 0; a < 4; a++) begin
            cfg.soft_act = a[1:0];
            cmd_pos = '0;
            tick(3);
            for (i = 0; i < 2; i++) begin
                cmd_pos = i ? 32'hFFFF_F000 : 32'h0000_1000;
                note(1, 0, 128'(2'h1 << i));
                note(1, 1, 128'(2'h2 >> i));
                note(1, 4, (a == 1) ? 128'h4 : (a == 2) ? 128'h2 : '0);
                tick(1);
            end
        end
        cfg.soft_en = 1'b0;
        cmd_pos = '0;
        cfg.tol = 16'h0040;
        for (i = 0; i < 4; i++) begin
            cfg.oos_en = (i != 2);
            lag = (i == 0) ? 32'h0000_0040
                : (i == 3) ? 32'hFFFF_FFBF : 32'h0000_0041;
            note(1, 0, (i % 2) ? 128'h4 : '0);
            note(1, 1, (i % 2) ? 128'h10 : '0);
            tick(1);
        end
        cfg.oos_en = 1'b0;
        cfg.trg_val = v + 32'h0000_0100;
        for (i = 0; i < 6; i++) begin
            cfg.comparator_readback_select = i[2:0];
            old = (i == 1) ? cfg.positive_soft_bound
                : (i == 2) ? cfg.negative_soft_bound
                : (i == 3) ? 32'(cfg.tol) : (i == 4) ? cfg.gp_val
                : (i == 5) ? cfg.trg_val : '0;
            note(1, 3, {96'h0, old});
            tick(1);
        end
        // Lag keeps command and feedback apart at the trigger point
        lag = 32'h0000_0003;
        for (m = 0; m < 2; m++) begin
            cfg.trigger_polarity_select = m[0];
            cfg.trg_method = `AXCL_METH_EQ;
            cmd_pos = '0;
            tick(4);
            cmd_pos = cfg.trg_val + lag;
            note(0, 2, 128'(!m[0]));
            note(1, 0, 128'h10);
            note(1, 1, 128'h4);
            for (i = 1; i <= PCYC + 1; i++) begin
                note(i, 2, 128'(m[0] ^ (i > PCYC)));
            end
            tick(PCYC + 3);
            cfg.trg_method = `AXCL_METH_OFF;
        end
        for (i = 0; i < 4; i++) begin
            cfg.latch_src = i[1:0];
            cfg.latch_cnt = 3'(i + 1);
            cmd_pos = 32'h0000_2000 + i;
            lag = i + 7;
            gp_pos = 32'h0000_7000 - i;
            old = latch_val;
            tick(2);
            ltc_lvl = (i == 0);
            home_lvl = (i == 3);
            cfg.gp_val = cmd_pos - lag;
            cfg.trg_val = cmd_pos - lag;
            cfg.compare_method_select = (i == 1) ? `AXCL_METH_EQ : '0;
            cfg.trg_method = (i == 2) ? `AXCL_METH_EQ : '0;
            for (m = 0; m < 12 && latch_val === old; m++) tick(1);
            v = (i == 0) ? cmd_pos : (i == 1) ? cmd_pos - lag
                : (i == 2) ? lag : gp_pos;
            note(1, 6, {95'h0, 1'b1, v});
            tick(2);
        end
        // Auto reload: FIFO words first, then the RAM service path
        cfg.auto_reload_select = 1'b1;
        cfg.reload_dev = 1'b1;
        cmd_pos = '0;
        lag = '0;
        fifo_data = 32'h0000_0040;
        fifo_valid = 1'b1;
        note(0, 7, '0);
        tick(1);
        cfg.trg_method = `AXCL_METH_EQ;
        note(0, 7, 128'h2);
        tick(1);
        fifo_data = 32'h0000_0080;
        cmd_pos = 32'h0000_0040;
        note(0, 7, 128'h2);
        note(1, 1, 128'h4);
        tick(1);
        fifo_valid = 1'b0;
        note(0, 7, '0);
        note(1, 3, 128'h80);
        tick(PCYC);
        cmd_pos = 32'h0000_0080;
        note(1, 0, 128'h10);
        tick(PCYC + 1);
        note(0, 7, 128'h2);
        note(1, 0, '0);
        tick(1);
        cfg.auto_reload_select = 1'b0;
        tick(1);
        cfg.auto_reload_select = 1'b1;
        cfg.reload_dev = 1'b0;
        ram_data = 32'h0000_00C0;
        note(1, 7, 128'h1);
        tick(1);
        ram_load = 1'b1;
        tick(1);
        ram_load = 1'b0;
        cmd_pos = 32'h0000_00C0;
        note(0, 7, '0);
        note(1, 1, 128'h4);
        tick(PCYC + 1);
        note(0, 7, 128'h1);
        tick(1);
        end_sim();
    end
endmodule : testbench
